// >>> core/tsr_defines.vh
// constants for the transceiver status readout block
// How it works
// - bits 0 and 1 show live local and remote wakeup flags, never cleared.
// - bit 2 always reads high.
// - bits 3 to 10 latch their internal flags once high.
// - bit 11 shows guardian enable in normal mode, low otherwise.
// - guardian enable is sampled for bit 11 on mode-control rising edges while a readout is open.
// - bits 12 to 15 always read low.
// - bits 16-23 and 24-31 hold fixed version bytes, never altered.
// - falling edges shift bits out inverted from bit 0, starting at second edge.
// - mode holds while toggling; steady input past filter time ends readout, sets mode.
// - at readout end, bits 4-10 clear only if shifted out and source clear.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH
// 20 us mode-change filter at the 4 ns core clock
`define TSR_MODE_FILTER_CYC 16'h1388
`define TSR_CNT_W 16
`define TSR_WORD_W 32
`define TSR_IDX_W 6
`define TSR_LAST_BIT 6'h1f
`define TSR_BIT_PAST 6'h20
`define TSR_STICKY_LO 3
`define TSR_STICKY_HI 10
`define TSR_CLEAR_LO 4
`define TSR_GUARD_BIT 11
`define TSR_VER_ANALOG 8'h11
`define TSR_VER_DIGITAL 8'h22
`define TSR_MODE_NORMAL 1'b1
`define TSR_STICKY_N 8
`define TSR_SHIFT_FALLS 2'h1
`define TSR_FALLS_IDLE 2'h0
`define TSR_PAD_LOW 4'h0
`define TSR_BIT2_LEVEL 1'b1
`endif

// >>> core/tsr_sync.v
// two-flop synchroniser for a pin level
`timescale 1ns/1ns
module tsr_sync
(
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // pin and synchronised level
    input wire i_pin,
    output reg o_level
);
    reg stage1;

    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            stage1 <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            stage1 <= i_pin;
            o_level <= stage1;
        end
    end
endmodule // tsr_sync

// >>> core/tsr_status_readout.v
// serial status word readout on the fault output, clocked by mode control
`timescale 1ns/1ns
`include "tsr_defines.vh"
module tsr_status_readout
#(
    parameter [`TSR_CNT_W-1:0] MODE_FILTER_CYC = `TSR_MODE_FILTER_CYC
)
(
    // clock and reset
    input wire i_core_clk,
    input wire i_rst_b,
    // host pins
    input wire i_mode_ctrl,
    input wire i_guardian_enable_in,
    // internal flags, same clock domain
    input wire i_local_wake,
    input wire i_remote_wake,
    input wire [7:0] i_flags,
    input wire i_fault_level_n,
    // outputs
    output reg o_fault_status_out_n,
    output reg o_mode_normal,
    output reg o_readout_active
);
    // synchronised pins and their edges
    wire en_s;
    wire guard_s;
    wire rise;
    wire fall;
    reg en_d;

    // time since the last mode-control edge
    reg [`TSR_CNT_W-1:0] stable_cnt;
    reg [`TSR_CNT_W-1:0] next_stable_cnt;
    wire settled;
    wire finish;

    // shift position within the word
    reg [1:0] falls;
    reg [1:0] next_falls;
    reg [`TSR_IDX_W-1:0] bit_idx;
    reg [`TSR_IDX_W-1:0] next_bit_idx;
    wire shifting;
    wire shift_now;

    // status word parts
    wire [`TSR_STICKY_N-1:0] sticky;
    wire [`TSR_STICKY_N-1:0] read_mask;
    reg guard_latch;
    wire guard_bit;
    wire [`TSR_WORD_W-1:0] word;
    reg next_out;
    genvar g;

    // slow host pins cross into the core clock first
    tsr_sync u_sync_en
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_mode_ctrl),
        .o_level(en_s)
    );

    tsr_sync u_sync_bg
    (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pin(i_guardian_enable_in),
        .o_level(guard_s)
    );

    // resets low like the pulled-down pin, so no false edge after reset
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            en_d <= 1'b0;
        else
            en_d <= en_s;
    end

    assign rise = en_s & ~en_d;
    assign fall = ~en_s & en_d;

    // restarts on every edge and parks once the filter time is reached
    always @*
    begin
        next_stable_cnt = stable_cnt;
        if (rise || fall)
            next_stable_cnt = {`TSR_CNT_W{1'b0}};
        else if (!settled)
            next_stable_cnt = stable_cnt + 1'b1;
    end

    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            stable_cnt <= {`TSR_CNT_W{1'b0}};
        else
            stable_cnt <= next_stable_cnt;
    end

    assign settled = (stable_cnt >= MODE_FILTER_CYC);
    // a fresh edge always wins over the end of a readout
    assign finish = settled & o_readout_active & ~rise & ~fall;

    // any edge starts a readout; mode is frozen meanwhile
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_readout_active <= 1'b0;
            o_mode_normal <= 1'b0;
        end
        else if (rise || fall)
        begin
            o_readout_active <= 1'b1;
        end
        else if (finish)
        begin
            o_readout_active <= 1'b0;
            o_mode_normal <= (en_s == `TSR_MODE_NORMAL);
        end
    end

    // the first falling edge only arms the shifter
    assign shifting = o_readout_active && (falls == `TSR_SHIFT_FALLS);
    assign shift_now = fall && shifting;

    always @*
    begin
        next_falls = falls;
        next_bit_idx = bit_idx;
        if (finish)
        begin
            next_falls = `TSR_FALLS_IDLE;
            next_bit_idx = {`TSR_IDX_W{1'b0}};
        end
        else if (fall)
        begin
            if (falls != `TSR_SHIFT_FALLS)
                next_falls = falls + 2'h1;
            // parks past the word, so a long host clock cannot wrap around
            if (shift_now && bit_idx != `TSR_BIT_PAST)
                next_bit_idx = bit_idx + 1'b1;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            falls <= `TSR_FALLS_IDLE;
            bit_idx <= {`TSR_IDX_W{1'b0}};
        end
        else
        begin
            falls <= next_falls;
            bit_idx <= next_bit_idx;
        end
    end

    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            guard_latch <= 1'b0;
        else if (rise && o_readout_active)
            guard_latch <= guard_s;
    end

    assign guard_bit = guard_latch & o_mode_normal;

    assign word = {`TSR_VER_DIGITAL, `TSR_VER_ANALOG,
                   `TSR_PAD_LOW,
                   guard_bit,
                   sticky,
                   `TSR_BIT2_LEVEL,
                   i_remote_wake, i_local_wake};

    always @*
    begin
        next_out = i_fault_level_n;
        if (shifting && bit_idx <= `TSR_LAST_BIT)
            next_out = ~word[bit_idx[4:0]];
        // past bit 31 the normal indication returns
        else if (shifting)
            next_out = i_fault_level_n;
    end

    // output moves only on falling edges while a readout is open
    always @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_fault_status_out_n <= 1'b1;
        else if (fall)
            o_fault_status_out_n <= next_out;
        else if (!o_readout_active)
            o_fault_status_out_n <= i_fault_level_n;
    end

    // one latch and one shown marker per sticky bit
    generate
        for (g = 0; g < `TSR_STICKY_N; g = g + 1)
        begin : g_sticky
            reg held;
            reg shown;

            always @(posedge i_core_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    shown <= 1'b0;
                else if (finish)
                    shown <= 1'b0;
                else if (shift_now && bit_idx == `TSR_STICKY_LO + g)
                    shown <= 1'b1;
            end

            // set wins over clear, so a flag firing at the end is kept
            always @(posedge i_core_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    held <= 1'b0;
                else if (i_flags[g])
                    held <= 1'b1;
                else if (finish && shown && (g >= `TSR_CLEAR_LO - `TSR_STICKY_LO))
                    held <= 1'b0;
            end

            assign sticky[g] = held;
            assign read_mask[g] = shown;
        end
    endgenerate

endmodule // tsr_status_readout

// >>> verif/tsr_assertions.sv
// port assertions for the status readout block
`timescale 1ns/1ns
module tsr_assertions #(parameter [15:0] MODE_FILTER_CYC = 16'h0028)
(
    // watched ports
    input wire i_core_clk,
    input wire i_rst_b,
    input wire i_mode_ctrl,
    input wire i_fault_level_n,
    input wire o_fault_status_out_n,
    input wire o_mode_normal,
    input wire o_readout_active
);
    reg [15:0] quiet;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // saturates so a long idle never wraps back into range
    always @(posedge i_core_clk or negedge i_rst_b)
        if (!i_rst_b) quiet <= 16'h0000;
        else quiet <= $changed(i_mode_ctrl) ? 16'h0000 : quiet + {15'h0000, ~&quiet};
    AST_START: assert property ($rose(i_mode_ctrl) |-> ##[1:6] o_readout_active)
        else $error("readout did not start");
    AST_FAULT_EDGE: assert property (
        $changed(o_fault_status_out_n) && o_readout_active |-> !$past(i_mode_ctrl, 2))
        else $error("fault output moved without a falling edge");
    AST_MODE_HOLD: assert property (
        o_readout_active ##1 o_readout_active |-> $stable(o_mode_normal))
        else $error("mode moved during readout");
    AST_END_MODE: assert property ($fell(o_readout_active) |-> o_mode_normal == i_mode_ctrl)
        else $error("mode does not follow pin at end");
    AST_END_BOUND: assert property (
        quiet == MODE_FILTER_CYC + 16'h0008 |-> !o_readout_active)
        else $error("readout outlived the filter time");
    AST_NO_EARLY_END: assert property (
        $changed(i_mode_ctrl) && o_readout_active |=> o_readout_active [*8])
        else $error("readout ended right after an edge");
    AST_QUIET: assert property (
        (!o_readout_active && $stable(i_mode_ctrl)) [*5] |=> !o_readout_active)
        else $error("readout started on a steady pin");
    AST_IDLE_FAULT: assert property (
        (!o_readout_active && $stable(i_fault_level_n)) [*3] |->
        o_fault_status_out_n == i_fault_level_n)
        else $error("idle fault level wrong");
endmodule // tsr_assertions

// >>> verif/tsr_host.sv
// host model clocking the status word out on the mode pin
`timescale 1ns/1ns
module tsr_host
(
    // clock and fault pin
    input wire i_core_clk,
    input wire i_fault_n,
    // mode pin
    output reg o_pin
);
    initial o_pin = 1'b0;
    // 10 core cycles a phase gives the 80 ns link clock; pin then rests at rest
    task read(input integer n, input rest, output [32:0] q);
        integer k;
        begin
            q = 33'h0;
            for (k = 0; k <= n; k = k + 1)
            begin
                @(posedge i_core_clk) o_pin <= 1'b1;
                repeat (10) @(posedge i_core_clk);
                o_pin <= 1'b0;
                repeat (9) @(posedge i_core_clk);
                if (k > 0) q[k-1] = i_fault_n;
            end
            @(posedge i_core_clk) o_pin <= rest;
        end
    endtask
endmodule // tsr_host

// >>> verif/tb.sv
// self-checking bench for the status readout block
`timescale 1ns/1ns
`include "tsr_defines.vh"
module tb;
    reg i_core_clk = 1'b0;
    reg i_rst_b = 1'b0;
    reg i_guardian_enable_in = 1'b1;
    reg i_local_wake = 1'b1;
    reg i_remote_wake = 1'b0;
    reg [7:0] i_flags = 8'h00;
    reg i_fault_level_n = 1'b1;
    wire i_mode_ctrl, o_fault_status_out_n, o_mode_normal, o_readout_active;
    integer n_fail = 0;
    integer tests_run = 0;
    always #2 i_core_clk = ~i_core_clk;
    tsr_status_readout #(.MODE_FILTER_CYC(16'h0028)) i_tsr_status_readout (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_mode_ctrl(i_mode_ctrl),
        .i_guardian_enable_in(i_guardian_enable_in), .i_local_wake(i_local_wake),
        .i_remote_wake(i_remote_wake), .i_flags(i_flags), .i_fault_level_n(i_fault_level_n),
        .o_fault_status_out_n(o_fault_status_out_n), .o_mode_normal(o_mode_normal),
        .o_readout_active(o_readout_active));
    tsr_host u_host (.i_core_clk(i_core_clk), .i_fault_n(o_fault_status_out_n),
        .o_pin(i_mode_ctrl));
    task test_done;
        begin
            if (n_fail == 0 && tests_run > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task check(input [32:0] got, input [32:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("BAD %0t %h %h", $time, got, exp);
            end
        end
    endtask
    // bit 11 carries the guardian level only while the mode is normal
    function [32:0] expw(input [7:0] st, input g);
        expw = {i_fault_level_n, ~{`TSR_VER_DIGITAL, `TSR_VER_ANALOG, 4'h0, g, st,
            1'b1, i_remote_wake, i_local_wake}};
    endfunction
    task rd(input integer n, input [32:0] exp, input [32:0] m, input rest);
        reg [32:0] q;
        integer i;
        begin
            u_host.read(n, rest, q);
            check(q & m, exp & m);
            for (i = 0; i < 200 && o_readout_active !== 1'b0; i = i + 1) @(posedge i_core_clk);
            if (i == 200) n_fail = n_fail + 1;
            if (i == 200) test_done;
            check({31'h0, o_mode_normal, o_readout_active}, {31'h0, rest, 1'b0});
        end
    endtask
    task sc_latch;
        begin
            @(posedge i_core_clk) i_flags <= 8'hff;
            @(posedge i_core_clk) i_flags <= 8'h00;
            rd(33, expw(8'hff, 1'b0), {33{1'b1}}, 1'b0);
        end
    endtask
    task sc_partial;
        begin
            @(posedge i_core_clk) i_flags <= 8'hff;
            i_remote_wake <= 1'b1;
            @(posedge i_core_clk) i_flags <= 8'h80;
            rd(6, expw(8'hff, 1'b0), 33'h3f, 1'b0);
            rd(33, expw(8'hf9, 1'b0), {33{1'b1}}, 1'b0);
        end
    endtask
    // pin left high enters normal mode; guardian and idle fault level vary
    task sc_normal;
        begin
            rd(33, expw(8'h81, 1'b0), {33{1'b1}}, 1'b1);
            rd(33, expw(8'h81, 1'b1), {33{1'b1}}, 1'b1);
            @(posedge i_core_clk) i_guardian_enable_in <= 1'b0;
            i_fault_level_n <= 1'b0;
            repeat (4) @(posedge i_core_clk);
            check({32'h0, o_fault_status_out_n}, 33'h0);
            rd(33, expw(8'h81, 1'b0), {33{1'b1}}, 1'b0);
            @(posedge i_core_clk) i_fault_level_n <= 1'b1;
        end
    endtask
    initial
    begin
        repeat (8) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        sc_latch;
        rd(33, expw(8'h01, 1'b0), {33{1'b1}}, 1'b0);
        sc_partial;
        sc_normal;
        test_done;
    end
endmodule // tb
bind tsr_status_readout tsr_assertions #(.MODE_FILTER_CYC(MODE_FILTER_CYC)) u_chk (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_mode_ctrl(i_mode_ctrl),
    .i_fault_level_n(i_fault_level_n), .o_fault_status_out_n(o_fault_status_out_n),
    .o_mode_normal(o_mode_normal), .o_readout_active(o_readout_active));
